// ---- verilog/memory_map_decoder.v ----
`include "memory_map_defines.vh"
module memory_map_decoder #(
    parameter NBLK = 32
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [23:0] prog_addr_i,
    input wire prog_req_i,
    input wire [23:0] data_addr_i,
    input wire data_req_i,
    input wire [31:0] dma_addr_i,
    input wire dma_req_i,
    input wire dma_io_i,
    input wire [31:0] usb_addr_i,
    input wire usb_req_i,
    input wire [31:0] lcd_addr_i,
    input wire lcd_req_i,
    input wire [15:0] io_addr_i,
    input wire io_req_i,
    input wire rom_unmap_wr_i,
    input wire rom_unmap_wdata_i,
    input wire soft_reset_i,
    output wire [5:0] ack_o,
    output wire [5:0] stall_o,
    output wire [5:0] zero_o,
    output wire [NBLK-1:0] sram_sel_o,
    output wire [3*NBLK-1:0] sram_owner_o,
    output wire rom_sel_o,
    output wire [2:0] rom_owner_o,
    output wire [15:0] rom_word_o,
    output wire [4:0] ext_cs_n_o,
    output wire [2:0] ext_owner_o,
    output wire [20:0] ext_addr_o,
    output wire io_sel_o,
    output wire [4:0] io_periph_o,
    output wire [15:0] io_word_o,
    output wire io_from_dma_o,
    output wire rom_unmap_bit_o
);
    // ======================================================================
    // decode functions
    // ======================================================================
    // region of a cpu byte address; rom wins over the external range
    function [1:0] cpu_region;
        input [23:0] a;
        input unmap;
        begin
            if (a >= `SRAM_CPU_LO && a <= `SRAM_CPU_HI)
                cpu_region = `RG_SRAM;
            else if (a >= `ROM_LO)
                cpu_region = unmap ? `RG_NONE : `RG_ROM;
            else if (a >= `EXT_LO)
                cpu_region = `RG_EXT;
            else
                cpu_region = `RG_NONE;
        end
    endfunction

    // region of a dma/usb/lcd byte address: only the ram window exists
    function [1:0] bus_region;
        input [31:0] a;
        begin
            if (a >= `SRAM_BUS_LO && a <= `SRAM_BUS_HI)
                bus_region = `RG_SRAM;
            else
                bus_region = `RG_NONE;
        end
    endfunction

    // ram block number: each block spans 8k bytes above the window base
    function [4:0] blk_of;
        input [31:0] a;
        input [31:0] base;
        reg [31:0] d;
        begin
            d = a - base;
            blk_of = d[`SRAM_BLK_LSB+4:`SRAM_BLK_LSB];
        end
    endfunction

    // external space index: 0 = cs0, 1..4 = cs2..cs5
    function [2:0] ext_space;
        input [23:0] a;
        begin
            if (a < `EXT_CS2_LO)
                ext_space = 3'h0;
            else if (a < `EXT_CS3_LO)
                ext_space = 3'h1;
            else if (a < `EXT_CS4_LO)
                ext_space = 3'h2;
            else if (a < `EXT_CS5_LO)
                ext_space = 3'h3;
            else
                ext_space = 3'h4;
        end
    endfunction

    // one-hot grant to master index
    function [2:0] owner_of;
        input [5:0] g;
        integer k;
        begin
            owner_of = `M_NONE;
            for (k = 5; k >= 0; k = k - 1) begin
                if (g[k])
                    owner_of = k[2:0];
            end
        end
    endfunction

    // ======================================================================
    // state
    // ======================================================================
    reg rom_unmap_r;
    reg [5:0] ack_r;
    reg [5:0] stall_r;
    reg [5:0] zero_r;
    reg [NBLK-1:0] sram_sel_r;
    reg [3*NBLK-1:0] sram_owner_r;
    reg rom_sel_r;
    reg [2:0] rom_owner_r;
    reg [15:0] rom_word_r;
    reg [4:0] ext_cs_n_r;
    reg [2:0] ext_owner_r;
    reg [20:0] ext_addr_r;
    reg io_sel_r;
    reg [4:0] io_periph_r;
    reg [15:0] io_word_r;
    reg io_from_dma_r;

    // ======================================================================
    // per-master decode of the five memory-space masters
    // ======================================================================
    wire [31:0] maddr [0:4];
    wire [4:0] mreq;
    wire [1:0] mreg [0:4];
    wire [4:0] mblk [0:4];

    assign maddr[0] = {8'h00, data_addr_i};
    assign maddr[1] = {8'h00, prog_addr_i};
    assign maddr[2] = dma_addr_i;
    assign maddr[3] = usb_addr_i;
    assign maddr[4] = lcd_addr_i;
    // a dma access goes either to memory or to i/o space, never both
    assign mreq = {lcd_req_i, usb_req_i, dma_req_i & ~dma_io_i,
                   prog_req_i, data_req_i};
    assign mreg[0] = cpu_region(data_addr_i, rom_unmap_r);
    assign mreg[1] = cpu_region(prog_addr_i, rom_unmap_r);
    assign mreg[2] = bus_region(dma_addr_i);
    assign mreg[3] = bus_region(usb_addr_i);
    assign mreg[4] = bus_region(lcd_addr_i);

    genvar m;
    generate
        for (m = 0; m < 5; m = m + 1) begin : g_blk
            assign mblk[m] = blk_of(maddr[m],
                (m < 2) ? {8'h00, `SRAM_CPU_LO} : `SRAM_BUS_LO);
        end
    endgenerate

    // ======================================================================
    // ram block arbitration, one arbiter per block
    // ======================================================================
    wire [5*NBLK-1:0] sram_gnt;
    genvar b;
    generate
        for (b = 0; b < NBLK; b = b + 1) begin : g_sram
            wire [4:0] req_b;
            for (m = 0; m < 5; m = m + 1) begin : g_req
                assign req_b[m] = mreq[m] && mreg[m] == `RG_SRAM &&
                                  mblk[m] == b;
            end
            // same-block collisions: one wins, the others stall
            resource_arbiter #(.N(5)) u_arb (
                .req_i(req_b),
                .grant_o(sram_gnt[5*b +: 5])
            );
        end
    endgenerate

    // ======================================================================
    // rom and external arbitration (program and data buses only)
    // ======================================================================
    wire [1:0] rom_req;
    wire [1:0] rom_gnt;
    wire [1:0] ext_req;
    wire [1:0] ext_gnt;

    assign rom_req = {mreq[1] && mreg[1] == `RG_ROM,
                      mreq[0] && mreg[0] == `RG_ROM};
    assign ext_req = {mreq[1] && mreg[1] == `RG_EXT,
                      mreq[0] && mreg[0] == `RG_EXT};

    resource_arbiter #(.N(2)) u_rom_arb (
        .req_i(rom_req),
        .grant_o(rom_gnt)
    );

    resource_arbiter #(.N(2)) u_ext_arb (
        .req_i(ext_req),
        .grant_o(ext_gnt)
    );

    // ======================================================================
    // i/o space: cpu i/o opcodes against dma, cpu first
    // ======================================================================
    wire [4:0] io_cpu_code;
    wire [4:0] io_dma_code;
    wire io_dma_ok;
    wire [1:0] io_req;
    wire [1:0] io_gnt;

    io_space_decoder u_io_cpu (
        .addr_i(io_addr_i),
        .periph_o(io_cpu_code),
        .dma_ok_o()
    );

    io_space_decoder u_io_dma (
        .addr_i(dma_addr_i[15:0]),
        .periph_o(io_dma_code),
        .dma_ok_o(io_dma_ok)
    );

    // reserved words and forbidden dma targets never reach a peripheral
    assign io_req = {dma_req_i & dma_io_i & io_dma_ok,
                     io_req_i & (io_cpu_code != `IO_NONE)};

    resource_arbiter #(.N(2)) u_io_arb (
        .req_i(io_req),
        .grant_o(io_gnt)
    );

    // ======================================================================
    // outcome per master: served, unmapped (zero), or stalled
    // ======================================================================
    reg [5:0] req_all;
    reg [5:0] served;
    reg [5:0] unmapped;
    integer j;
    always @* begin
        req_all = {io_req_i, mreq[4:3], dma_req_i, mreq[1:0]};
        served = {io_gnt[0], 3'h0, rom_gnt[1] | ext_gnt[1],
                  rom_gnt[0] | ext_gnt[0]};
        served[`M_DMA] = io_gnt[1];
        for (j = 0; j < NBLK; j = j + 1)
            served[4:0] = served[4:0] | sram_gnt[5*j +: 5];
        unmapped = 6'h00;
        for (j = 0; j < 5; j = j + 1)
            unmapped[j] = mreq[j] && mreg[j] == `RG_NONE;
        unmapped[`M_DMA] = unmapped[`M_DMA] |
                           (dma_req_i & dma_io_i & ~io_dma_ok);
        unmapped[`M_IOC] = io_req_i && io_cpu_code == `IO_NONE;
    end

    // ======================================================================
    // rom unmap bit
    // ======================================================================
    // soft_reset_i is deliberately not looked at here
    always @(posedge clk_sys_i) begin
        if (!rst_n_i)
            rom_unmap_r <= 1'b0;
        else if (ce_i && rom_unmap_wr_i)
            rom_unmap_r <= rom_unmap_wdata_i;
    end

    // ======================================================================
    // handshake flags
    // ======================================================================
    // an unmapped access completes at once and reads as zero
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ack_r <= 6'h00;
            stall_r <= 6'h00;
            zero_r <= 6'h00;
        end else if (ce_i) begin
            ack_r <= served | unmapped;
            stall_r <= req_all & ~served & ~unmapped;
            zero_r <= unmapped;
        end
    end

    // ======================================================================
    // ram block selects and owners
    // ======================================================================
    integer n;
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sram_sel_r <= {NBLK{1'b0}};
            sram_owner_r <= {(3*NBLK){1'b1}};
        end else if (ce_i) begin
            for (n = 0; n < NBLK; n = n + 1) begin
                sram_sel_r[n] <= |sram_gnt[5*n +: 5];
                sram_owner_r[3*n +: 3] <=
                    owner_of({1'b0, sram_gnt[5*n +: 5]});
            end
        end
    end

    // ======================================================================
    // rom port
    // ======================================================================
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rom_sel_r <= 1'b0;
            rom_owner_r <= `M_NONE;
            rom_word_r <= 16'h0000;
        end else if (ce_i) begin
            rom_sel_r <= |rom_gnt;
            rom_owner_r <= owner_of({4'h0, rom_gnt});
            if (rom_gnt[0])
                rom_word_r <= data_addr_i[16:1];
            else if (rom_gnt[1])
                rom_word_r <= prog_addr_i[16:1];
        end
    end

    // ======================================================================
    // external chip selects and address
    // ======================================================================
    // selects are active low; only the granted space's pin drops
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ext_cs_n_r <= 5'h1F;
            ext_owner_r <= `M_NONE;
            ext_addr_r <= 21'h000000;
        end else if (ce_i) begin
            ext_cs_n_r <= 5'h1F;
            ext_owner_r <= owner_of({4'h0, ext_gnt});
            if (ext_gnt[0]) begin
                ext_cs_n_r[ext_space(data_addr_i)] <= 1'b0;
                ext_addr_r <= data_addr_i[21:1];
            end else if (ext_gnt[1]) begin
                ext_cs_n_r[ext_space(prog_addr_i)] <= 1'b0;
                ext_addr_r <= prog_addr_i[21:1];
            end
        end
    end

    // ======================================================================
    // i/o space select
    // ======================================================================
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            io_sel_r <= 1'b0;
            io_periph_r <= `IO_NONE;
            io_word_r <= 16'h0000;
            io_from_dma_r <= 1'b0;
        end else if (ce_i) begin
            io_sel_r <= |io_gnt;
            io_from_dma_r <= io_gnt[1];
            if (io_gnt[0]) begin
                io_periph_r <= io_cpu_code;
                io_word_r <= io_addr_i;
            end else if (io_gnt[1]) begin
                io_periph_r <= io_dma_code;
                io_word_r <= dma_addr_i[15:0];
            end else begin
                io_periph_r <= `IO_NONE;
            end
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign ack_o = ack_r;
    assign stall_o = stall_r;
    assign zero_o = zero_r;
    assign sram_sel_o = sram_sel_r;
    assign sram_owner_o = sram_owner_r;
    assign rom_sel_o = rom_sel_r;
    assign rom_owner_o = rom_owner_r;
    assign rom_word_o = rom_word_r;
    assign ext_cs_n_o = ext_cs_n_r;
    assign ext_owner_o = ext_owner_r;
    assign ext_addr_o = ext_addr_r;
    assign io_sel_o = io_sel_r;
    assign io_periph_o = io_periph_r;
    assign io_word_o = io_word_r;
    assign io_from_dma_o = io_from_dma_r;
    assign rom_unmap_bit_o = rom_unmap_r;
endmodule // memory_map_decoder

// ---- verilog/memory_map_defines.vh ----
`ifndef MEMORY_MAP_DEFINES_VH
`define MEMORY_MAP_DEFINES_VH
// ==========================================================================
// masters, in falling priority order for every memory-space target; in i/o space M_IOC beats M_DMA
// ==========================================================================
`define M_DATA 3'h0
`define M_PROG 3'h1
`define M_DMA 3'h2
`define M_USB 3'h3
`define M_LCD 3'h4
`define M_IOC 3'h5
`define M_NONE 3'h7
// ==========================================================================
// region kinds of a memory-space access
// ==========================================================================
`define RG_NONE 2'h0
`define RG_SRAM 2'h1
`define RG_ROM 2'h2
`define RG_EXT 2'h3
// ==========================================================================
// memory-space byte addresses
// ==========================================================================
`define SRAM_CPU_LO 24'h010000
`define SRAM_CPU_HI 24'h04FFFF
`define SRAM_BUS_LO 32'h00090000
`define SRAM_BUS_HI 32'h000CFFFF
`define SRAM_BLK_LSB 13
`define ROM_LO 24'hFE0000
`define EXT_LO 24'h050000
`define EXT_CS2_LO 24'h400000
`define EXT_CS3_LO 24'h800000
`define EXT_CS4_LO 24'hC00000
`define EXT_CS5_LO 24'hE00000
// ==========================================================================
// i/o-space peripheral codes
// ==========================================================================
`define IO_NONE 5'h00
`define IO_IDLE 5'h01
`define IO_DMA0 5'h02
`define IO_EXTIF 5'h06
`define IO_TMR0 5'h07
`define IO_RTC 5'h0A
`define IO_I2C 5'h0B
`define IO_UART 5'h0C
`define IO_SYSCTL 5'h0D
`define IO_I2S0 5'h0E
`define IO_LCD 5'h12
`define IO_SPI 5'h13
`define IO_CARD0 5'h14
`define IO_SAR 5'h16
`define IO_USB 5'h17
`endif

// ---- verilog/resource_arbiter.v ----
`include "memory_map_defines.vh"
// fixed-priority arbiter: the lowest requester index wins the target
module resource_arbiter #(
    parameter N = 5
) (
    input wire [N-1:0] req_i,
    output reg [N-1:0] grant_o
);
    integer i;
    reg taken;
    // ======================================================================
    // priority pick
    // ======================================================================
    // one grant at most, so a single-port target never sees two accesses
    always @* begin
        taken = 1'b0;
        grant_o = {N{1'b0}};
        for (i = 0; i < N; i = i + 1) begin
            if (req_i[i] && !taken) begin
                grant_o[i] = 1'b1;
                taken = 1'b1;
            end
        end
    end
endmodule // resource_arbiter

// ---- verilog/io_space_decoder.v ----
`include "memory_map_defines.vh"
// word address of the 64k i/o space to a peripheral code
module io_space_decoder (
    input wire [15:0] addr_i,
    output reg [4:0] periph_o,
    output reg dma_ok_o
);
    // ======================================================================
    // range decode
    // ======================================================================
    // gaps between ranges stay IO_NONE, so reserved words select nothing
    always @* begin
        periph_o = `IO_NONE;
        if (addr_i <= 16'h0004)
            periph_o = `IO_IDLE;
        else if (addr_i[15:10] == 6'h03 && addr_i[7] == 1'b0)
            periph_o = `IO_DMA0 + {3'h0, addr_i[9:8]};
        else if (addr_i >= 16'h1000 && addr_i <= 16'h10DD)
            periph_o = `IO_EXTIF;
        else if (addr_i[15:8] == 8'h18 && addr_i[7:6] != 2'h3 &&
                 addr_i[5] == 1'b0)
            periph_o = `IO_TMR0 + {3'h0, addr_i[7:6]};
        else if (addr_i >= 16'h1900 && addr_i <= 16'h197F)
            periph_o = `IO_RTC;
        else if (addr_i >= 16'h1A00 && addr_i <= 16'h1A6C)
            periph_o = `IO_I2C;
        else if (addr_i >= 16'h1B00 && addr_i <= 16'h1B1F)
            periph_o = `IO_UART;
        else if (addr_i[15:8] == 8'h1C)
            periph_o = `IO_SYSCTL;
        else if (addr_i[15:10] == 6'h0A && addr_i[7:0] <= 8'h40)
            periph_o = `IO_I2S0 + {3'h0, addr_i[9:8]};
        else if (addr_i >= 16'h2E00 && addr_i <= 16'h2E40)
            periph_o = `IO_LCD;
        else if (addr_i >= 16'h3000 && addr_i <= 16'h300F)
            periph_o = `IO_SPI;
        else if (addr_i[15:9] == 7'h1D && addr_i[7:5] == 3'h0)
            periph_o = `IO_CARD0 + {4'h0, addr_i[8]};
        else if (addr_i[15:8] == 8'h70)
            periph_o = `IO_SAR;
        else if (addr_i[15])
            periph_o = `IO_USB;
    end

    // ======================================================================
    // peripherals that a dma channel may reach in i/o space
    // ======================================================================
    always @* begin
        case (periph_o)
            `IO_I2C, `IO_UART, `IO_EXTIF, `IO_USB, `IO_SAR,
            `IO_CARD0, `IO_CARD0 + 5'h01,
            `IO_I2S0, `IO_I2S0 + 5'h01, `IO_I2S0 + 5'h02,
            `IO_I2S0 + 5'h03: dma_ok_o = 1'b1;
            default: dma_ok_o = 1'b0;
        endcase
    end
endmodule // io_space_decoder

// ---- sim/memory_map_chk.sv ----
// ==========================================
// decoder checker
// ==========================================
module memory_map_chk #(
    parameter NBLK = 32
) (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic ce_i,
    input logic [23:0] prog_addr_i,
    input logic prog_req_i,
    input logic [23:0] data_addr_i,
    input logic data_req_i,
    input logic [15:0] io_addr_i,
    input logic io_req_i,
    input logic rom_unmap_wr_i,
    input logic rom_unmap_wdata_i,
    input logic soft_reset_i,
    input logic [5:0] ack_o,
    input logic [5:0] stall_o,
    input logic [5:0] zero_o,
    input logic [NBLK-1:0] sram_sel_o,
    input logic rom_sel_o,
    input logic [4:0] ext_cs_n_o,
    input logic io_sel_o,
    input logic [4:0] io_periph_o,
    input logic rom_unmap_bit_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // data ram hits; data has top priority so it is never stalled
    sequence s_ram;
        ce_i && data_req_i && data_addr_i >= 24'h010000
            && data_addr_i <= 24'h04FFFF;
    endsequence
    sequence s_rom;
        ce_i && data_req_i && data_addr_i >= 24'hFE0000;
    endsequence
    sequence s_unmap;
        ce_i && rom_unmap_wr_i && rom_unmap_wdata_i;
    endsequence
    AST_RAM_BLK: assert property (s_ram |=> ack_o[0] && !zero_o[0] &&
        sram_sel_o[$past(data_addr_i[18:13]) - 6'h08])
        else $error("ram block select wrong");
    AST_SAME_BLK: assert property (s_ram ##0 (prog_req_i &&
        prog_addr_i[23:13] == data_addr_i[23:13]) |=> stall_o[1] && !ack_o[1])
        else $error("second access to a block not stalled");
    AST_ROM_MAP: assert property (s_rom ##0 !rom_unmap_bit_o |=>
        rom_sel_o && ack_o[0] && !zero_o[0]) else $error("rom not selected");
    AST_ROM_GONE: assert property (s_rom ##0 rom_unmap_bit_o |=>
        zero_o[0] && ack_o[0] && !rom_sel_o) else $error("rom still mapped");
    AST_HW_CLEAR: assert property ($rose(rst_n_i) |-> !rom_unmap_bit_o)
        else $error("unmap bit survived reset");
    AST_SOFT_KEEP: assert property (soft_reset_i && !rom_unmap_wr_i |=>
        $stable(rom_unmap_bit_o)) else $error("soft reset moved unmap bit");
    AST_EXT_CS0: assert property (ce_i && data_req_i &&
        data_addr_i >= 24'h050000 && data_addr_i < 24'h400000 |=>
        ext_cs_n_o == 5'h1E) else $error("first select pin not driven");
    AST_IO_UART: assert property (ce_i && io_req_i &&
        io_addr_i[15:5] == 11'h0D8 |=> io_sel_o && io_periph_o == 5'h0C)
        else $error("uart i/o decode wrong");
    AST_IO_RSVD: assert property (ce_i && io_req_i && io_addr_i >= 16'h0005 &&
        io_addr_i <= 16'h0BFF |=> ack_o[5] && zero_o[5] && !io_sel_o)
        else $error("reserved i/o word answered");
endmodule // memory_map_chk
bind memory_map_decoder memory_map_chk #(.NBLK(NBLK)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .prog_addr_i(prog_addr_i), .prog_req_i(prog_req_i),
    .data_addr_i(data_addr_i), .data_req_i(data_req_i),
    .io_addr_i(io_addr_i), .io_req_i(io_req_i),
    .rom_unmap_wr_i(rom_unmap_wr_i), .rom_unmap_wdata_i(rom_unmap_wdata_i),
    .soft_reset_i(soft_reset_i), .ack_o(ack_o), .stall_o(stall_o),
    .zero_o(zero_o), .sram_sel_o(sram_sel_o), .rom_sel_o(rom_sel_o),
    .ext_cs_n_o(ext_cs_n_o), .io_sel_o(io_sel_o), .io_periph_o(io_periph_o),
    .rom_unmap_bit_o(rom_unmap_bit_o));

// ---- sim/dma_master_model.sv ----
// ==========================================
// dma master model
// ==========================================
module dma_master_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic stall_i,
    output logic req_o,
    output logic io_o,
    output logic [31:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // memory only, no peripheral registers, ram window past boot area
    initial begin
        req_o = 1'b0;
        io_o = 1'b0;
        addr_o = 32'h0;
    end
    // reissue while stalled; a released address shows its inverse
    always @(negedge clk_i) begin
        if (go_i) begin
            req_o <= 1'b1;
            addr_o <= addr_i;
        end else if (req_o && !stall_i) begin
            req_o <= 1'b0;
            addr_o <= ~addr_o;
        end
    end
endmodule // dma_master_model

// ---- sim/tb_top.sv ----
`include "memory_map_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1, go = 0;
    logic prog_req_i = 0, data_req_i = 0, io_req_i = 0;
    logic unmap_wr = 0, unmap_wd = 0, soft_rst = 0, dma_req, dma_io;
    logic [23:0] prog_addr_i = 0, data_addr_i = 0, a;
    logic [15:0] io_addr_i = 0;
    logic [31:0] go_addr = 0, dma_addr;
    wire [5:0] ack_o, stall_o, zero_o;
    wire [31:0] sram_sel_o;
    wire [95:0] sram_owner_o;
    wire [15:0] rom_word_o;
    wire [20:0] ext_addr_o;
    wire [4:0] ext_cs_n_o, io_periph_o;
    wire rom_sel_o, io_sel_o, rom_unmap_bit_o;
    int mismatches = 0, n_checks = 0, cyc = 0;
    logic [15:0] ia[15] = '{16'h0000, 16'h0C00, 16'h0D00, 16'h1000, 16'h1840,
        16'h1900, 16'h1A00, 16'h1B00, 16'h1C00, 16'h2E00, 16'h3000, 16'h3B00,
        16'h7000, 16'h8000, 16'h0800};
    logic [4:0] ic[15] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h08, 5'h0A, 5'h0B,
        5'h0C, 5'h0D, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h00};
    logic [23:0] xl[5] = '{24'h050000, 24'h400000, 24'h800000, 24'hC00000,
        24'hE00000};
    memory_map_decoder #(.NBLK(32)) i_dut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .ce_i(ce_i), .prog_addr_i(prog_addr_i),
        .prog_req_i(prog_req_i), .data_addr_i(data_addr_i),
        .data_req_i(data_req_i), .dma_addr_i(dma_addr), .dma_req_i(dma_req),
        .dma_io_i(dma_io), .usb_addr_i(32'h0), .usb_req_i(1'b0),
        .lcd_addr_i(32'h0), .lcd_req_i(1'b0), .io_addr_i(io_addr_i),
        .io_req_i(io_req_i), .rom_unmap_wr_i(unmap_wr),
        .rom_unmap_wdata_i(unmap_wd), .soft_reset_i(soft_rst), .ack_o(ack_o),
        .stall_o(stall_o), .zero_o(zero_o), .sram_sel_o(sram_sel_o),
        .sram_owner_o(sram_owner_o), .rom_sel_o(rom_sel_o), .rom_owner_o(),
        .rom_word_o(rom_word_o), .ext_cs_n_o(ext_cs_n_o), .ext_owner_o(),
        .ext_addr_o(ext_addr_o), .io_sel_o(io_sel_o),
        .io_periph_o(io_periph_o), .io_word_o(), .io_from_dma_o(),
        .rom_unmap_bit_o(rom_unmap_bit_o));
    dma_master_model i_dma (.clk_i(clk_sys_i), .go_i(go), .addr_i(go_addr),
        .stall_i(stall_o[2]), .req_o(dma_req), .io_o(dma_io),
        .addr_o(dma_addr));
    // ==========================================
    // clock, timeout, helpers
    // ==========================================
    initial forever #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    function automatic logic [4:0] exp_cs(input logic [23:0] x);
        if (x < 24'h400000) return 5'h1E;
        if (x < 24'h800000) return 5'h1D;
        if (x < 24'hC00000) return 5'h1B;
        if (x < 24'hE00000) return 5'h17;
        return 5'h0F;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one attempt by data (p=0) or program (p=1); ends after the answer
    task automatic mem(input logic [23:0] x, input bit p);
        @(negedge clk_sys_i);
        if (p) {prog_req_i, prog_addr_i} <= {1'b1, x};
        else {data_req_i, data_addr_i} <= {1'b1, x};
        @(negedge clk_sys_i);
        {prog_req_i, data_req_i} <= 2'b00;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        void'($urandom(32'hD603));
        repeat (4) @(negedge clk_sys_i);
        rst_n_i <= 1;
        @(negedge clk_sys_i);
        chk("unmap_rst", rom_unmap_bit_o, 0);
        for (int n = 0; n < 32; n++) begin
            a = 24'h010000 + n * 24'h2000 + (24'($urandom % 8192) |
                (n == 31 ? 24'h001000 : 24'h000000));
            mem(a, n[0]);
            chk("ram_sel", sram_sel_o, 32'h1 << n);
            chk("ram_ack", ack_o[n[0]], 1);
        end
        // data and program collide on one block: program waits
        @(negedge clk_sys_i);
        {data_req_i, prog_req_i, data_addr_i, prog_addr_i} <=
            {2'b11, 24'h012010, 24'h013000};
        @(negedge clk_sys_i);
        {data_req_i, prog_req_i} <= 2'b00;
        chk("clash", {stall_o[1], ack_o[1:0]}, 3'b101);
        // dma loses block 5 to data once, then gets it through its window
        @(negedge clk_sys_i);
        {go, go_addr} <= {1'b1, 32'h0009A000 + 32'($urandom % 8192)};
        @(negedge clk_sys_i);
        go <= 0;
        {data_req_i, data_addr_i} <= {1'b1, 24'h01A000};
        @(negedge clk_sys_i);
        data_req_i <= 0;
        chk("dma_stall", {stall_o[2], ack_o[0]}, 2'b11);
        @(negedge clk_sys_i);
        chk("dma_sel", sram_sel_o, 32'h20);
        chk("dma_own", sram_owner_o[17:15], `M_DMA);
        a = 24'hFE0000 + 24'($urandom % 24'h20000);
        mem(a, 1);
        chk("rom_sel", {rom_sel_o, rom_word_o}, {1'b1, a[16:1]});
        @(negedge clk_sys_i);
        {unmap_wr, unmap_wd} <= 2'b11;
        @(negedge clk_sys_i);
        {unmap_wr, soft_rst} <= 2'b01;
        @(negedge clk_sys_i);
        soft_rst <= 0;
        mem(24'hFE0010, 0);
        chk("unmapped", {rom_sel_o, zero_o[0]}, 2'b01);
        chk("soft_keep", rom_unmap_bit_o, 1);
        rst_n_i <= 0;
        @(negedge clk_sys_i);
        rst_n_i <= 1;
        mem(24'hFF0000, 0);
        chk("rom_back", {rom_sel_o, rom_unmap_bit_o}, 2'b10);
        for (int i = 0; i < 5; i++) begin
            a = xl[i] + 24'($urandom % 24'h10000);
            mem(a, i[0]);
            chk("ext_cs", ext_cs_n_o, exp_cs(a));
            chk("ext_addr", ext_addr_o, a[21:1]);
        end
        for (int i = 0; i < 15; i++) begin
            @(negedge clk_sys_i);
            {io_req_i, io_addr_i} <= {1'b1, ia[i]};
            @(negedge clk_sys_i);
            io_req_i <= 0;
            chk("io_code", io_periph_o, ic[i]);
            chk("io_zero", zero_o[5], ic[i] == 5'h00);
        end
        tally_and_finish;
    end
endmodule // tb_top
